// file: design/rfc_pkg.sv
// Constants for the receive-frame result counters.
// Assumes a byte-wide register port with byte addresses as printed.
package rfc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned LANE_W  = 2;

  // ----------------------------------------------------------------
  // Byte addresses of the low byte of each counter
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SUCCESS_COUNT_ADDR  = 16'h014c;
  localparam logic [ADDR_W-1:0] CRC_FAIL_COUNT_ADDR = 16'h0150;

  // ----------------------------------------------------------------
  // Values after reset, unmapped read value and count step
  // ----------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  RDATA_RESET  = 8'h00;
  localparam logic [DATA_W-1:0]  UNMAPPED_VAL = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_ONE    = 32'h0000_0001;

endpackage

// file: design/rfc_event_counter.sv
// One 32-bit frame event counter.
// Assumes inc is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module rfc_event_counter (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        inc,
  output logic [rfc_pkg::COUNT_W-1:0]      count_value
);

  logic [rfc_pkg::COUNT_W-1:0] count_reg;
  logic [rfc_pkg::COUNT_W-1:0] count_next;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  // Plain modulo add: all ones rolls over to zero
  always_comb begin
    count_next = count_reg;
    if (inc) begin
      count_next = rfc_pkg::COUNT_W'(count_reg + rfc_pkg::COUNT_ONE);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= rfc_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_value = count_reg;

endmodule

`default_nettype wire

// file: design/rfc_counters.sv
// Receive-frame result counters: success and CRC-fail frame counts.
// Assumes frame outcome strobes and register strobes are synchronous to clock.
//
// What this block does
// - Count frames passing header and CRC checks
// - Count frames passing header, failing CRC
// - Success count: read-only, 014CH-014FH, resets zero
// - CRC-fail count: read-only, 0150H-0153H, resets zero
`timescale 1ns/1ps
`default_nettype none

module rfc_counters (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        frame_done,
  input  wire logic                        phr_pass,
  input  wire logic                        crc_pass,
  input  wire logic [rfc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [rfc_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [rfc_pkg::DATA_W-1:0]  rd_data
);

  // ----------------------------------------------------------------
  // Byte lane selection
  // ----------------------------------------------------------------
  function automatic logic [rfc_pkg::DATA_W-1:0] lane_select(
    input logic [rfc_pkg::COUNT_W-1:0] value,
    input logic [rfc_pkg::LANE_W-1:0]  lane
  );
    logic [rfc_pkg::DATA_W-1:0] b;
    b = value[rfc_pkg::DATA_W*lane +: rfc_pkg::DATA_W];
    return b;
  endfunction

  function automatic logic word_hit(
    input logic [rfc_pkg::ADDR_W-1:0] a,
    input logic [rfc_pkg::ADDR_W-1:0] base
  );
    return a[rfc_pkg::ADDR_W-1:rfc_pkg::LANE_W] == base[rfc_pkg::ADDR_W-1:rfc_pkg::LANE_W];
  endfunction

  // ----------------------------------------------------------------
  // Frame outcome qualification
  // ----------------------------------------------------------------
  logic success_inc;
  logic crc_fail_inc;
  logic [rfc_pkg::COUNT_W-1:0] success_count_value;
  logic [rfc_pkg::COUNT_W-1:0] crc_fail_count_value;

  // Header failures land in neither counter
  assign success_inc  = frame_done & phr_pass & crc_pass;
  assign crc_fail_inc = frame_done & phr_pass & ~crc_pass;

  rfc_event_counter u_success (
    .clock       (clock),
    .rst         (rst),
    .inc         (success_inc),
    .count_value (success_count_value)
  );

  rfc_event_counter u_crc_fail (
    .clock       (clock),
    .rst         (rst),
    .inc         (crc_fail_inc),
    .count_value (crc_fail_count_value)
  );

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [rfc_pkg::DATA_W-1:0] rd_data_reg;
  logic [rfc_pkg::DATA_W-1:0] rd_data_next;

  // No snapshot on purpose: a multi-byte read may tear while counting,
  // software handles that by re-reading the low byte.
  // Writes have no path into the counters, so wr_data is never stored.
  always_comb begin
    rd_data_next = rfc_pkg::RDATA_RESET;
    if (rd_en) begin
      if (word_hit(addr, rfc_pkg::SUCCESS_COUNT_ADDR)) begin
        rd_data_next = lane_select(success_count_value, addr[rfc_pkg::LANE_W-1:0]);
      end else if (word_hit(addr, rfc_pkg::CRC_FAIL_COUNT_ADDR)) begin
        rd_data_next = lane_select(crc_fail_count_value, addr[rfc_pkg::LANE_W-1:0]);
      end else begin
        rd_data_next = rfc_pkg::UNMAPPED_VAL;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_reg <= rfc_pkg::RDATA_RESET;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic wr_seen;
  assign wr_seen = wr_en;

  property p_success_step;
    success_inc |=> success_count_value == rfc_pkg::COUNT_W'($past(success_count_value) + rfc_pkg::COUNT_ONE);
  endproperty
  a_success_step: assert property (p_success_step) else $error("success count did not step by one");

  property p_crc_fail_step;
    crc_fail_inc |=> crc_fail_count_value == rfc_pkg::COUNT_W'($past(crc_fail_count_value) + rfc_pkg::COUNT_ONE);
  endproperty
  a_crc_fail_step: assert property (p_crc_fail_step) else $error("crc fail count did not step by one");

  property p_success_hold;
    !(frame_done && phr_pass && crc_pass) |=> $stable(success_count_value);
  endproperty
  a_success_hold: assert property (p_success_hold) else $error("success count moved without a good frame");

  property p_crc_fail_hold;
    !(frame_done && phr_pass && !crc_pass) |=> $stable(crc_fail_count_value);
  endproperty
  a_crc_fail_hold: assert property (p_crc_fail_hold) else $error("crc fail count moved without a bad frame");

  property p_header_fail_ignored;
    frame_done && !phr_pass |=> $stable(success_count_value) && $stable(crc_fail_count_value);
  endproperty
  a_header_fail_ignored: assert property (p_header_fail_ignored) else $error("header failure was counted");

  property p_success_read;
    rd_en && word_hit(addr, rfc_pkg::SUCCESS_COUNT_ADDR)
      |=> rd_data == lane_select($past(success_count_value), $past(addr[rfc_pkg::LANE_W-1:0]));
  endproperty
  a_success_read: assert property (p_success_read) else $error("wrong success count byte read");

  property p_crc_fail_read;
    rd_en && word_hit(addr, rfc_pkg::CRC_FAIL_COUNT_ADDR)
      |=> rd_data == lane_select($past(crc_fail_count_value), $past(addr[rfc_pkg::LANE_W-1:0]));
  endproperty
  a_crc_fail_read: assert property (p_crc_fail_read) else $error("wrong crc fail count byte read");

  property p_write_ignored;
    wr_seen && !frame_done ##1 !frame_done |=> $stable(success_count_value) && $stable(crc_fail_count_value);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("register write changed a counter");

  property p_success_wrap;
    success_inc && (&success_count_value) |=> success_count_value == rfc_pkg::COUNT_RESET;
  endproperty
  a_success_wrap: assert property (p_success_wrap) else $error("success count did not wrap to zero");

  // Byte carry is the part of the wrap path that a short run can reach
  property p_success_carry;
    success_inc && (&success_count_value[rfc_pkg::DATA_W-1:0])
      |=> success_count_value[rfc_pkg::DATA_W-1:0] == rfc_pkg::RDATA_RESET
          && success_count_value[rfc_pkg::COUNT_W-1:rfc_pkg::DATA_W]
             == rfc_pkg::COUNT_W'(rfc_pkg::COUNT_W'($past(success_count_value)) + rfc_pkg::COUNT_ONE) >> rfc_pkg::DATA_W;
  endproperty
  a_success_carry: assert property (p_success_carry) else $error("success count low byte did not carry");

  property p_crc_fail_carry;
    crc_fail_inc && (&crc_fail_count_value[rfc_pkg::DATA_W-1:0])
      |=> crc_fail_count_value[rfc_pkg::DATA_W-1:0] == rfc_pkg::RDATA_RESET
          && crc_fail_count_value[rfc_pkg::COUNT_W-1:rfc_pkg::DATA_W]
             == rfc_pkg::COUNT_W'(rfc_pkg::COUNT_W'($past(crc_fail_count_value)) + rfc_pkg::COUNT_ONE) >> rfc_pkg::DATA_W;
  endproperty
  a_crc_fail_carry: assert property (p_crc_fail_carry) else $error("crc fail count low byte did not carry");

  property p_idle_read_zero;
    !rd_en |=> rd_data == rfc_pkg::RDATA_RESET;
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside its cycle");

  property p_reset_clear;
    @(posedge clock) rst |=> success_count_value == rfc_pkg::COUNT_RESET
                            && crc_fail_count_value == rfc_pkg::COUNT_RESET && rd_data == rfc_pkg::RDATA_RESET;
  endproperty
  a_reset_clear: assert property (disable iff (1'b0) p_reset_clear) else $error("reset did not clear");

  c_success_event: cover property (success_inc ##1 rd_en && word_hit(addr, rfc_pkg::SUCCESS_COUNT_ADDR));
  c_crc_fail_event: cover property (crc_fail_inc ##1 rd_en && word_hit(addr, rfc_pkg::CRC_FAIL_COUNT_ADDR));
  c_low_byte_zero: cover property (rd_en && addr == rfc_pkg::SUCCESS_COUNT_ADDR ##1 rd_data == 8'h00
                                   && success_count_value != rfc_pkg::COUNT_RESET);
  c_back_to_back: cover property (rd_en ##1 rd_en ##1 wr_en);

endmodule

`default_nettype wire

// file: verification/tb_rfc_counters.sv
// Self-checking bench for the receive-frame result counters.
// Assumes rfc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module tb_rfc_counters;
  logic                          clock      = 1'b0;
  logic                          rst        = 1'b1;
  logic                          frame_done = 1'b0;
  logic                          phr_pass   = 1'b0;
  logic                          crc_pass   = 1'b0;
  logic [rfc_pkg::ADDR_W-1:0]    addr       = 16'h0000;
  logic [rfc_pkg::DATA_W-1:0]    wr_data    = 8'h00;
  logic                          wr_en      = 1'b0;
  logic                          rd_en      = 1'b0;
  logic [rfc_pkg::DATA_W-1:0]    rd_data;
  logic [rfc_pkg::COUNT_W-1:0]   exp_ok     = 32'h0000_0000;
  logic [rfc_pkg::COUNT_W-1:0]   exp_ng     = 32'h0000_0000;
  logic [rfc_pkg::DATA_W-1:0]    d;
  int                            n_fail          = 0;
  int                            samples_checked = 0;

  rfc_counters dut_u (
    .clock      (clock),
    .rst        (rst),
    .frame_done (frame_done),
    .phr_pass   (phr_pass),
    .crc_pass   (crc_pass),
    .addr       (addr),
    .wr_data    (wr_data),
    .wr_en      (wr_en),
    .rd_en      (rd_en),
    .rd_data    (rd_data)
  );

  always #4 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus and frame tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Data stands only in the cycle after the read edge
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= v;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask

  // Bytes are live, so no frames may run while this reads
  task automatic read_count(input logic [15:0] base, input logic [31:0] exp);
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      rd(base + 16'(i), v);
      check({24'h000000, v}, {24'h000000, exp[8*i +: 8]});
      if (i == 0 && v == 8'h00) begin
        rd(base, v);
        check({24'h000000, v}, {24'h000000, exp[7:0]});
      end
    end
  endtask

  // Back-to-back outcome strobes, one frame per cycle
  task automatic frames(input logic p, input logic c, input int n);
    @(posedge clock);
    frame_done <= 1'b1;
    phr_pass   <= p;
    crc_pass   <= c;
    repeat (n) @(posedge clock);
    frame_done <= 1'b0;
    if (p && c) exp_ok += 32'(n);
    else if (p) exp_ng += 32'(n);
  endtask

  task automatic both();
    read_count(rfc_pkg::SUCCESS_COUNT_ADDR, exp_ok);
    read_count(rfc_pkg::CRC_FAIL_COUNT_ADDR, exp_ng);
  endtask

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    both();
    frames(1'b1, 1'b1, 3);
    frames(1'b1, 1'b0, 2);
    frames(1'b0, 1'b1, 4);
    frames(1'b0, 1'b0, 1);
    both();
    for (int i = 0; i < 8; i++) wr(rfc_pkg::SUCCESS_COUNT_ADDR + 16'(i), 8'hff);
    both();
    rd(16'h0154, d);
    check({24'h000000, d}, 32'h0000_0000);
    rd(16'h014b, d);
    check({24'h000000, d}, 32'h0000_0000);
    @(posedge clock);
    #1 check({24'h000000, rd_data}, 32'h0000_0000);
    // Read in the cycle of a frame sees the old count
    @(posedge clock);
    frame_done <= 1'b1;
    phr_pass   <= 1'b1;
    crc_pass   <= 1'b1;
    rd_en      <= 1'b1;
    addr       <= rfc_pkg::SUCCESS_COUNT_ADDR;
    @(posedge clock);
    frame_done <= 1'b0;
    rd_en      <= 1'b0;
    #1 check({24'h000000, rd_data}, {24'h000000, exp_ok[7:0]});
    exp_ok += 32'h0000_0001;
    // Low byte rolls to 00 and carries into the next byte
    frames(1'b1, 1'b1, 256 - int'(exp_ok[7:0]));
    frames(1'b1, 1'b0, 256 - int'(exp_ng[7:0]));
    both();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst    <= 1'b0;
    exp_ok  = 32'h0000_0000;
    exp_ng  = 32'h0000_0000;
    both();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
